// File: src/lcdbk_pkg.sv
// Package: register map, field layout, reset values and modes of the LCD blink and memory control block
package lcdbk_pkg;
    localparam int unsigned LCDBK_WORDS = 8;
    localparam int unsigned LCDBK_DW = 8;
    localparam int unsigned LCDBK_SEGS = LCDBK_WORDS * LCDBK_DW;
    // Byte addresses on the bus, one aligned 32-bit word each
    localparam logic [7:0] LCDBK_OFS_BLKCTL = 8'h00;
    localparam logic [7:0] LCDBK_OFS_MEMCTL = 8'h04;
    localparam logic [7:0] LCDBK_OFS_IFG = 8'h08;
    localparam logic [7:0] LCDBK_OFS_IE = 8'h0C;
    localparam logic [7:0] LCDBK_OFS_MUXCFG = 8'h10;
    localparam logic [7:0] LCDBK_OFS_SEGMEM = 8'h40;
    localparam logic [7:0] LCDBK_OFS_BLKMEM = 8'h60;
    localparam logic [7:0] LCDBK_MEM_SPAN = 8'h20;
    // Field positions
    localparam int unsigned LCDBK_MODE_LSB = 0;
    localparam int unsigned LCDBK_PRE_LSB = 2;
    localparam int unsigned LCDBK_DISP_BIT = 0;
    localparam int unsigned LCDBK_CLRM_BIT = 1;
    localparam int unsigned LCDBK_CLRBM_BIT = 2;
    localparam int unsigned LCDBK_OFF_BIT = 0;
    localparam int unsigned LCDBK_ON_BIT = 1;
    localparam int unsigned LCDBK_MUX_LSB = 0;
    // Reset values
    localparam logic [1:0] LCDBK_MODE_RST = 2'h0;
    localparam logic [2:0] LCDBK_PRE_RST = 3'h0;
    localparam logic [2:0] LCDBK_MUX_RST = 3'h0;
    localparam logic [1:0] LCDBK_FLAG_RST = 2'h0;
    // Mux code of 5-mux; at and above it the memory-based blink modes stop
    localparam logic [2:0] LCDBK_MUX_5 = 3'h4;
    // Wait cycles of a register read
    localparam logic [1:0] LCDBK_RD_WAIT = 2'h2;
    typedef enum logic [1:0] {
        LCDBK_BLINK_OFF = 2'b00,
        LCDBK_BLINK_SEG = 2'b01,
        LCDBK_BLINK_ALL = 2'b10,
        LCDBK_BLINK_SWAP = 2'b11
    } lcdbk_mode_e;
endpackage

// File: src/lcdbk_mem.sv
// Segment and blink memory banks with walking bulk clear and registered read port
`timescale 1ns/100ps
module lcdbk_mem
    import lcdbk_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire logic wr_bank_in,
    input wire logic [2:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_bank_in,
    input wire logic [2:0] rd_idx_in,
    output logic [7:0] rd_data_out,
    input wire logic [1:0] clr_req_in,
    output logic [1:0] clr_done_out,
    output logic [63:0] seg_bits_out,
    output logic [63:0] blk_bits_out
);
    logic [63:0] bank_bits [2];
    logic [7:0] rd_data_ff;

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            logic [7:0] mem_ff [LCDBK_WORDS];
            logic [2:0] clr_idx_ff;
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    for (int i = 0; i < LCDBK_WORDS; i++) begin
                        mem_ff[i] <= 8'h00;
                    end
                end else begin
                    if (wr_en_in && (wr_bank_in == b[0])) begin
                        mem_ff[wr_idx_in] <= wr_data_in;
                    end
                    // Clear beats a write to the same word
                    if (clr_req_in[b]) begin
                        mem_ff[clr_idx_ff] <= 8'h00;
                    end
                end
            end
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    clr_idx_ff <= 3'h0;
                end else if (clr_req_in[b]) begin
                    clr_idx_ff <= clr_idx_ff + 3'h1;
                end else begin
                    clr_idx_ff <= 3'h0;
                end
            end
            assign clr_done_out[b] = clr_req_in[b] && (clr_idx_ff == 3'h7);
            for (genvar w = 0; w < LCDBK_WORDS; w++) begin : g_word
                assign bank_bits[b][w*8 +: 8] = mem_ff[w];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= bank_bits[rd_bank_in][{rd_idx_in, 3'h0} +: 8];
        end
    end

    assign rd_data_out = rd_data_ff;
    assign seg_bits_out = bank_bits[0];
    assign blk_bits_out = bank_bits[1];
endmodule // lcdbk_mem

// File: src/lcdbk_top.sv
// LCD blink clock, blink modes, display memory select and bulk clear control with Avalon-MM registers
`timescale 1ns/100ps
module lcdbk_top
    import lcdbk_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic frame_tick_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [63:0] seg_drive_out,
    output logic blink_clock_out,
    output logic irq_out
);
    logic [1:0] mode_ff;
    logic [2:0] prescale_ff;
    logic [2:0] mux_rate_ff;
    logic disp_sel_ff;
    logic nxt_disp_sel;
    logic clr_seg_ff;
    logic clr_blk_ff;
    logic [1:0] flag_ff;
    logic [1:0] mask_ff;
    logic [11:0] frm_cnt_ff;
    logic [11:0] half_period;
    logic blink_clk_ff;
    logic blink_rise;
    logic blink_fall;
    logic [1:0] rd_cnt_ff;
    logic [31:0] readdata_ff;
    logic [63:0] seg_drive_ff;
    logic [63:0] seg_bits;
    logic [63:0] blk_bits;
    logic [7:0] mem_rd_data;
    logic [1:0] clr_done;
    logic wr_lane;
    logic wr_blkctl;
    logic wr_memctl;
    logic wr_ifg;
    logic wr_ie;
    logic wr_mux;
    logic in_mem;
    logic mem_bank;
    logic mem_wr;
    logic mux_high;
    logic [7:0] wd;
    lcdbk_mode_e mode;

    assign mode = lcdbk_mode_e'(mode_ff);
    assign wd = avs_writedata_in[7:0];
    assign wr_lane = avs_write_in && avs_byteenable_in[0];
    assign wr_blkctl = wr_lane && (avs_address_in == LCDBK_OFS_BLKCTL);
    assign wr_memctl = wr_lane && (avs_address_in == LCDBK_OFS_MEMCTL);
    assign wr_ifg = wr_lane && (avs_address_in == LCDBK_OFS_IFG);
    assign wr_ie = wr_lane && (avs_address_in == LCDBK_OFS_IE);
    assign wr_mux = wr_lane && (avs_address_in == LCDBK_OFS_MUXCFG);
    assign in_mem = (avs_address_in >= LCDBK_OFS_SEGMEM) && (avs_address_in < LCDBK_OFS_BLKMEM + LCDBK_MEM_SPAN)
        && (avs_address_in[1:0] == 2'h0);
    assign mem_bank = avs_address_in >= LCDBK_OFS_BLKMEM;
    assign mem_wr = wr_lane && in_mem;
    // 5-mux and above disable memory based blinking and blink memory clearing
    assign mux_high = mux_rate_ff >= LCDBK_MUX_5;

    // Control fields
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_ff <= LCDBK_MODE_RST;
            prescale_ff <= LCDBK_PRE_RST;
            mux_rate_ff <= LCDBK_MUX_RST;
            mask_ff <= LCDBK_FLAG_RST;
        end else begin
            if (wr_blkctl) begin
                mode_ff <= wd[LCDBK_MODE_LSB +: 2];
                prescale_ff <= wd[LCDBK_PRE_LSB +: 3];
            end
            if (wr_mux) begin
                mux_rate_ff <= wd[LCDBK_MUX_LSB +: 3];
            end
            if (wr_ie) begin
                mask_ff <= wd[1:0];
            end
        end
    end

    // Blink clock: toggles every half period of frames; held low while blinking is off
    assign half_period = 12'((({9'h0, mux_rate_ff} + 12'h1) << ({1'b0, prescale_ff} + 4'h1)));

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            frm_cnt_ff <= 12'h000;
            blink_clk_ff <= 1'b0;
        end else if (mode == LCDBK_BLINK_OFF) begin
            frm_cnt_ff <= 12'h000;
            blink_clk_ff <= 1'b0;
        end else if (frame_tick_in) begin
            // A mid-blink divisor change may run one period long; software avoids it
            if (frm_cnt_ff >= half_period - 12'h1) begin
                frm_cnt_ff <= 12'h000;
                blink_clk_ff <= ~blink_clk_ff;
            end else begin
                frm_cnt_ff <= frm_cnt_ff + 12'h1;
            end
        end
    end

    assign blink_rise = (mode != LCDBK_BLINK_OFF) && frame_tick_in && !blink_clk_ff
        && (frm_cnt_ff >= half_period - 12'h1);
    assign blink_fall = (mode != LCDBK_BLINK_OFF) && frame_tick_in && blink_clk_ff
        && (frm_cnt_ff >= half_period - 12'h1);

    // Event flags: set wins over a memory-write or W1C clear
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flag_ff <= LCDBK_FLAG_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == LCDBK_ON_BIT && blink_rise) || (i == LCDBK_OFF_BIT && blink_fall)) begin
                    flag_ff[i] <= 1'b1;
                end else if (mem_wr || (wr_ifg && wd[i])) begin
                    flag_ff[i] <= 1'b0;
                end
            end
        end
    end

    assign irq_out = |(flag_ff & mask_ff);

    // Display memory select
    always_comb begin
        nxt_disp_sel = disp_sel_ff;
        if (mux_high || mode == LCDBK_BLINK_SEG || mode == LCDBK_BLINK_ALL) begin
            nxt_disp_sel = 1'b0;
        end else if (mode == LCDBK_BLINK_SWAP) begin
            nxt_disp_sel = ~blink_clk_ff;
        end else if (wr_memctl) begin
            nxt_disp_sel = wd[LCDBK_DISP_BIT];
        end
        if (wr_blkctl && mode == LCDBK_BLINK_SWAP && wd[LCDBK_MODE_LSB +: 2] == LCDBK_BLINK_OFF) begin
            nxt_disp_sel = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            disp_sel_ff <= 1'b0;
        end else begin
            disp_sel_ff <= nxt_disp_sel;
        end
    end

    // Bulk clears stay set while the walker runs
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clr_seg_ff <= 1'b0;
            clr_blk_ff <= 1'b0;
        end else begin
            if (wr_memctl && wd[LCDBK_CLRM_BIT]) begin
                clr_seg_ff <= 1'b1;
            end else if (clr_done[0]) begin
                clr_seg_ff <= 1'b0;
            end
            if (wr_memctl && wd[LCDBK_CLRBM_BIT] && !mux_high) begin
                clr_blk_ff <= 1'b1;
            end else if (clr_done[1] || mux_high) begin
                clr_blk_ff <= 1'b0;
            end
        end
    end

    lcdbk_mem u_mem (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(mem_wr),
        .wr_bank_in(mem_bank),
        .wr_idx_in(avs_address_in[4:2]),
        .wr_data_in(wd),
        .rd_bank_in(mem_bank),
        .rd_idx_in(avs_address_in[4:2]),
        .rd_data_out(mem_rd_data),
        .clr_req_in({clr_blk_ff, clr_seg_ff}),
        .clr_done_out(clr_done),
        .seg_bits_out(seg_bits),
        .blk_bits_out(blk_bits)
    );

    // Segment drive
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            seg_drive_ff <= 64'h0;
        end else begin
            case (mode)
                LCDBK_BLINK_ALL: seg_drive_ff <= blink_clk_ff ? seg_bits : 64'h0;
                LCDBK_BLINK_SEG: begin
                    if (mux_high || blink_clk_ff) begin
                        seg_drive_ff <= seg_bits;
                    end else begin
                        seg_drive_ff <= seg_bits & ~blk_bits;
                    end
                end
                default: seg_drive_ff <= disp_sel_ff ? blk_bits : seg_bits;
            endcase
        end
    end

    assign seg_drive_out = seg_drive_ff;
    assign blink_clock_out = blink_clk_ff;

    // Reads take two wait cycles: memory word, then the bus data register
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_cnt_ff <= 2'h0;
        end else if (avs_read_in && rd_cnt_ff != LCDBK_RD_WAIT) begin
            rd_cnt_ff <= rd_cnt_ff + 2'h1;
        end else begin
            rd_cnt_ff <= 2'h0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            readdata_ff <= 32'h0;
        end else if (avs_read_in && rd_cnt_ff == 2'h1) begin
            readdata_ff <= 32'h0;
            if (in_mem) begin
                readdata_ff[7:0] <= mem_rd_data;
            end else begin
                case (avs_address_in)
                    LCDBK_OFS_BLKCTL: readdata_ff[4:0] <= {prescale_ff, mode_ff};
                    LCDBK_OFS_MEMCTL: readdata_ff[2:0] <= {clr_blk_ff, clr_seg_ff, disp_sel_ff};
                    LCDBK_OFS_IFG: readdata_ff[1:0] <= flag_ff;
                    LCDBK_OFS_IE: readdata_ff[1:0] <= mask_ff;
                    LCDBK_OFS_MUXCFG: readdata_ff[2:0] <= mux_rate_ff;
                    default: readdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign avs_readdata_out = readdata_ff;
    assign avs_waitrequest_out = avs_read_in && (rd_cnt_ff != LCDBK_RD_WAIT);

    // Checks
    a_blink_half_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        frm_cnt_ff < half_period || mode == LCDBK_BLINK_OFF || $changed(half_period))
        else $error("blink frame counter ran past half period");
    a_blink_edge_tick: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $changed(blink_clk_ff) && $past(mode) != LCDBK_BLINK_OFF |-> $past(frame_tick_in))
        else $error("blink clock moved without a frame tick");
    a_mode_off_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_OFF |=> !blink_clk_ff)
        else $error("blink clock ran while blinking disabled");
    a_on_flag_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(blink_clk_ff) |-> flag_ff[LCDBK_ON_BIT])
        else $error("blink-on flag not set on rise");
    a_off_flag_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(blink_clk_ff) && $past(mode) != LCDBK_BLINK_OFF |-> flag_ff[LCDBK_OFF_BIT])
        else $error("blink-off flag not set on fall");
    a_flag_mem_clr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mem_wr && !blink_rise && !blink_fall |=> flag_ff == 2'h0)
        else $error("memory write did not clear flags");
    a_flag_w1c: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_ifg && wd[LCDBK_OFF_BIT] && !blink_fall |=> !flag_ff[LCDBK_OFF_BIT])
        else $error("write one did not clear blink-off flag");
    a_disp_held_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mux_high || mode == LCDBK_BLINK_SEG || mode == LCDBK_BLINK_ALL |=> !disp_sel_ff)
        else $error("display select not held at zero");
    a_disp_swap_track: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_SWAP && !mux_high && !wr_blkctl |=> disp_sel_ff == !$past(blink_clk_ff))
        else $error("display select does not track shown memory");
    a_disp_back_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_blkctl && mode == LCDBK_BLINK_SWAP && wd[LCDBK_MODE_LSB +: 2] == LCDBK_BLINK_OFF |=> !disp_sel_ff)
        else $error("display select not cleared on return to mode 00");
    a_disp_sw_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_memctl && mode == LCDBK_BLINK_OFF && !mux_high |=> disp_sel_ff == $past(wd[LCDBK_DISP_BIT]))
        else $error("display select write not taken in mode 00");
    a_clrbm_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mux_high |=> !clr_blk_ff)
        else $error("blink memory clear ran at high mux");
    a_clrbm_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_memctl && wd[LCDBK_CLRBM_BIT] && !mux_high |=> clr_blk_ff)
        else $error("blink memory clear did not start");
    a_clrm_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_memctl && wd[LCDBK_CLRM_BIT] |=> clr_seg_ff)
        else $error("segment memory clear did not start");
    a_clrm_done: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(clr_seg_ff) |-> clr_seg_ff [*8] ##1 (!clr_seg_ff || $past(wr_memctl)))
        else $error("segment clear did not finish in eight cycles");
    a_all_off_half: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_ALL && !blink_clk_ff |=> seg_drive_ff == 64'h0)
        else $error("segments not off in off half");
    a_all_on_half: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_ALL && blink_clk_ff |=> seg_drive_ff == $past(seg_bits))
        else $error("segments not shown in on half");
    a_seg_blink_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_SEG && !mux_high && !blink_clk_ff |=> (seg_drive_ff & $past(blk_bits)) == 64'h0)
        else $error("blinked segment shown in off half");
    a_seg_on_half: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_SEG && blink_clk_ff |=> seg_drive_ff == $past(seg_bits))
        else $error("segment memory not shown in on half");
    a_seg_mux_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_SEG && mux_high |=> seg_drive_ff == $past(seg_bits))
        else $error("segment blink not suppressed at high mux");
    a_seg_default: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mode == LCDBK_BLINK_OFF && !disp_sel_ff |=> seg_drive_ff == $past(seg_bits))
        else $error("segment memory not displayed");
    // Bus timing
    a_write_no_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        avs_write_in |-> !avs_waitrequest_out)
        else $error("write was stalled");
    a_read_wait_two: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(avs_read_in) |-> avs_waitrequest_out ##1 avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("read did not answer after two wait cycles");

    c_swap_mode: cover property (@(posedge clk_in) mode == LCDBK_BLINK_SWAP && $rose(disp_sel_ff));
    c_blk_clear: cover property (@(posedge clk_in) $fell(clr_blk_ff));
    c_seg_clear: cover property (@(posedge clk_in) $fell(clr_seg_ff));
    c_all_blink: cover property (@(posedge clk_in) mode == LCDBK_BLINK_ALL && $fell(blink_clk_ff));
    c_irq: cover property (@(posedge clk_in) $rose(irq_out));
endmodule // lcdbk_top

// File: dv/lcdbk_glass.sv
// Partner model: LCD glass that paces frames and latches the segment drive once per frame
`timescale 1ns/100ps
module lcdbk_glass (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] gap_in,
    input wire logic [63:0] seg_drive_in,
    output logic frame_tick_out,
    output logic [63:0] shown_out
);
    logic [3:0] cnt_ff;
    logic last;
    assign last = (cnt_ff + 4'h1) >= gap_in;
    // Frame length comes from the bench so blink timing is seen at several paces
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_ff <= 4'h0;
            frame_tick_out <= 1'b0;
        end else begin
            frame_tick_out <= last;
            cnt_ff <= last ? 4'h0 : cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) shown_out <= 64'h0;
        else if (frame_tick_out) shown_out <= seg_drive_in;
    end
endmodule // lcdbk_glass

// File: dv/lcdbk_top_test.sv
// Self-checking bench of the LCD blink and display memory control block
`timescale 1ns/100ps
module lcdbk_top_test
    import lcdbk_pkg::*;
;
    localparam logic [7:0] BC = LCDBK_OFS_BLKCTL;
    localparam logic [7:0] MC = LCDBK_OFS_MEMCTL;
    localparam logic [7:0] MX = LCDBK_OFS_MUXCFG;
    localparam logic [7:0] SM = LCDBK_OFS_SEGMEM;
    localparam logic [7:0] BM = LCDBK_OFS_BLKMEM;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, rd_en = 1'b0, wr_en = 1'b0;
    logic [7:0] addr = 8'h00, sdat, bdat;
    logic [31:0] wdat = 32'h0, seed = 32'h5A, last_rd;
    logic [3:0] ben = 4'h0, gap = 4'h3;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40, 8'h60, 8'h20};
    wire frame_tick, wreq, blk, irq;
    wire [31:0] rdat;
    wire [63:0] seg, shown;
    logic [1:0] md_list [3] = '{2'b10, 2'b01, 2'b11};
    int failures = 0, n_compared = 0, ticks = 0;
    always #2 clk_in = ~clk_in;
    lcdbk_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .frame_tick_in(frame_tick), .avs_address_in(addr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_byteenable_in(ben),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .seg_drive_out(seg), .blink_clock_out(blk),
        .irq_out(irq));
    lcdbk_glass u_glass (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .gap_in(gap), .seg_drive_in(seg),
        .frame_tick_out(frame_tick), .shown_out(shown));
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("BAD at %0t: %s seen %0h want %0h", $time, what, seen, want);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Completed reads are judged here against the oldest note of the driver
    always @(posedge clk_in) begin
        if (rd_en && wreq === 1'b0) begin
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                if (e[32]) check(rdat, e[31:0], "read data");
            end
        end
    end
    always @(posedge clk_in) if (frame_tick === 1'b1) ticks++;
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input bit chk,
                       input logic [31:0] x, input logic [3:0] b);
        int n;
        n = 0;
        if (!w) exp_q.push_back({chk, x});
        @(posedge clk_in);
        addr <= a;
        wdat <= d;
        ben <= b;
        wr_en <= w;
        rd_en <= !w;
        // Hold the request until waitrequest is sampled low at a rising edge; read data are taken there
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        last_rd = rdat;
        if (n >= 50) begin
            failures++;
            stop_test();
        end
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        // Return on a falling edge so callers look at settled outputs
        @(negedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0, 32'h0, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0, 1'b1, x, 4'hF);
    endtask
    task automatic wait_blink(input logic lv);
        int n;
        n = 0;
        while (blk !== lv && n < 5000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 5000) begin
            failures++;
            stop_test();
        end
        // Swap mode shows the new memory two cycles after the blink clock moves
        repeat (2) @(negedge clk_in);
    endtask
    task automatic poll(input int bitn);
        int n;
        n = 0;
        bus(1'b0, MC, 32'h0, 1'b0, 32'h0, 4'hF);
        check(last_rd[bitn], 1'b1, "clear running");
        while (last_rd[bitn] !== 1'b0 && n < 30) begin
            bus(1'b0, MC, 32'h0, 1'b0, 32'h0, 4'hF);
            n++;
        end
        check(last_rd[bitn], 1'b0, "clear self reset");
    endtask
    function automatic logic [63:0] want(input logic [1:0] md, input logic lv);
        if (lv) return {56'h0, sdat};
        return {56'h0, md == 2'b10 ? 8'h00 : md == 2'b01 ? (sdat & ~bdat) : bdat};
    endfunction
    initial begin
        logic [1:0] md;
        logic lv;
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        // Mux rate first, so it never changes while blinking runs
        wr(MX, 32'hFFFF_FFFF);
        rd(MX, 32'h7);
        wr(BC, 32'hFFFF_FFFF);
        rd(BC, 32'h1F);
        bus(1'b1, BC, 32'h0, 1'b0, 32'h0, 4'h0);
        rd(BC, 32'h1F);
        $display("test registers done");
        // Every mux code and every prescale code, with blinking stopped around each change
        for (int i = 0; i < 8; i++) begin
            wr(BC, 32'h0);
            check(blk, 1'b0, "blink idle");
            gap <= 4'(2 + rnd() % 3);
            wr(MX, 32'(i));
            wr(BC, 32'({3'(7 - i), 2'b10}));
            wait_blink(1'b1);
            ticks = 0;
            wait_blink(1'b0);
            check(ticks, (64'(i) + 1) << (8 - i), "half period");
        end
        $display("test blink rate done");
        sdat = 8'(rnd());
        bdat = 8'(rnd());
        wr(BC, 32'h0);
        wr(MX, 32'h0);
        wr(SM, 32'(sdat));
        wr(BM, 32'(bdat));
        wr(MC, 32'h1);
        rd(MC, 32'h1);
        check(seg, {56'h0, bdat}, "display blink memory");
        foreach (md_list[k]) begin
            md = md_list[k];
            wr(BC, 32'({3'd3, md}));
            for (int j = 1; j >= 0; j--) begin
                lv = j[0];
                wait_blink(lv);
                check(seg, want(md, lv), "segment drive");
                repeat (5) @(negedge clk_in);
                check(shown, want(md, lv), "glass shows drive");
                wr(MC, 32'(lv));
                rd(MC, md == 2'b11 ? 32'(!lv) : 32'h0);
            end
        end
        wr(BC, 32'h0);
        rd(MC, 32'h0);
        $display("test blink modes done");
        wr(MX, 32'h4);
        wr(BC, 32'h1);
        wait_blink(1'b0);
        check(seg, {56'h0, sdat}, "no segment blink at 5-mux");
        wr(BC, 32'h3);
        wait_blink(1'b0);
        check(seg, {56'h0, sdat}, "no memory swap at 5-mux");
        rd(MC, 32'h0);
        wr(BC, 32'h0);
        wr(MC, 32'h5);
        rd(MC, 32'h0);
        rd(BM, 32'(bdat));
        wr(MX, 32'h0);
        wr(MC, 32'h4);
        poll(LCDBK_CLRBM_BIT);
        rd(BM, 32'h0);
        rd(SM, 32'(sdat));
        wr(MC, 32'h2);
        poll(LCDBK_CLRM_BIT);
        rd(SM, 32'h0);
        $display("test clears done");
        wr(BC, 32'({3'd3, 2'b10}));
        wait_blink(1'b1);
        wait_blink(1'b0);
        wr(LCDBK_OFS_IFG, 32'h3);
        wr(LCDBK_OFS_IE, 32'h2);
        @(negedge clk_in);
        check(irq, 1'b0, "irq idle");
        wait_blink(1'b1);
        check(irq, 1'b1, "irq on rise");
        rd(LCDBK_OFS_IFG, 32'h2);
        wr(SM + 8'h04, rnd());
        rd(LCDBK_OFS_IFG, 32'h0);
        check(irq, 1'b0, "flags cleared by memory write");
        wr(LCDBK_OFS_IE, 32'h1);
        wait_blink(1'b0);
        check(irq, 1'b1, "irq on fall");
        wr(LCDBK_OFS_IFG, 32'h1);
        @(negedge clk_in);
        check(irq, 1'b0, "irq after clear");
        $display("test interrupts done");
        stop_test();
    end
endmodule // lcdbk_top_test
